//--- design/its_defs.svh
// constants for the i2c timeout supervisor
`ifndef ITS_DEFS_SVH
`define ITS_DEFS_SVH
`define ITS_CNT_W 24
`define ITS_NUM_TMR 5
`define ITS_T_SCL 0
`define ITS_T_ARB 1
`define ITS_T_BYTE 2
`define ITS_T_TRN 3
`define ITS_T_BOOT 4
`define ITS_NUM_EVT 8
`define ITS_E_SCL_S 0
`define ITS_E_SCL_M 1
`define ITS_E_ARB 2
`define ITS_E_MBYTE 3
`define ITS_E_SBYTE 4
`define ITS_E_MTRN 5
`define ITS_E_STRN 6
`define ITS_E_BOOT 7
`define ITS_NUM_STAT 4
`define ITS_S_SAFAIL 0
`define ITS_S_MATMO 1
`define ITS_S_MAATMO 2
`define ITS_S_BLFAIL 3
`define ITS_CLK_PERIOD_NS 25
`define ITS_IDLE_DETECT_NS 50000
`define ITS_IDLE_CYC ((`ITS_IDLE_DETECT_NS + `ITS_CLK_PERIOD_NS - 1) / `ITS_CLK_PERIOD_NS)
`define ITS_IDLE_W 12
`endif

//--- design/its_pkg.sv
// types for the i2c timeout supervisor
`include "its_defs.svh"
package its_pkg;
   typedef logic [`ITS_CNT_W-1:0] its_cnt_t;
   typedef logic [`ITS_NUM_EVT-1:0] its_evt_t;
   typedef logic [`ITS_NUM_STAT-1:0] its_stat_t;
   typedef enum logic [1:0] {
      ITS_RS_IDLE = 2'b00,
      ITS_RS_MASTER = 2'b01,
      ITS_RS_SLAVE = 2'b10,
      ITS_RS_BOOT = 2'b11
   } its_resp_t;
endpackage

//--- design/its_tmr_if.sv
// bundle between supervisor and its timer bank
`timescale 1ns/1ps
`include "its_defs.svh"
interface its_tmr_if;
   import its_pkg::*;
   logic [`ITS_NUM_TMR-1:0] run;
   logic [`ITS_NUM_TMR-1:0] restart;
   logic [`ITS_NUM_TMR-1:0] expire;
   its_cnt_t period [`ITS_NUM_TMR];
   modport ctl (output run, output restart, output period, input expire);
   modport tmr (input run, input restart, input period, output expire);
endinterface

//--- design/its_timer_bank.sv
// bank of timeout counters, one per timeout kind
`timescale 1ns/1ps
`include "its_defs.svh"
module its_timer_bank (
   input wire logic core_clk,
   input wire logic rst_n,
   its_tmr_if.tmr t
);
   import its_pkg::*;
   genvar i;
   generate
      for (i = 0; i < `ITS_NUM_TMR; i++)
      begin : g_tmr
         its_cnt_t cnt_q;
         its_cnt_t cnt_d;
         logic exp_q;
         logic exp_d;
         always_comb
         begin
            cnt_d = cnt_q;
            exp_d = 1'b0;
            // a zero period disables the timer outright
            if (!t.run[i] || t.restart[i] || t.period[i] == '0)
               cnt_d = '0;
            else if (cnt_q != t.period[i])
            begin
               cnt_d = its_cnt_t'(cnt_q + 1'b1);
               exp_d = (cnt_q == its_cnt_t'(t.period[i] - 1'b1));
            end
         end
         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               cnt_q <= '0;
               exp_q <= 1'b0;
            end
            else
            begin
               cnt_q <= cnt_d;
               exp_q <= exp_d;
            end
         end
         assign t.expire[i] = exp_q;
      end
   endgenerate
endmodule

//--- design/its_timeout_supervisor.sv
// i2c timeout supervisor: five timeouts, abort control, events and status
`timescale 1ns/1ps
`include "its_defs.svh"
module its_timeout_supervisor (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic serial_data_line_in,
   input wire logic master_active,
   input wire logic slave_active,
   input wire logic master_start_launch,
   input wire logic master_addr_sending,
   input wire logic master_addr_done,
   input wire logic master_addr_collision,
   input wire logic master_waiting_idle,
   input wire logic master_lost_bus,
   input wire logic master_own_bit,
   input wire logic byte_strobe,
   input wire logic boot_active,
   input wire logic boot_end_normal,
   input wire logic boot_byte_done,
   input wire logic clock_low_en,
   input wire logic byte_timeout_en,
   input wire logic trans_timeout_en,
   input its_pkg::its_cnt_t clock_low_period,
   input its_pkg::its_cnt_t arb_period,
   input its_pkg::its_cnt_t byte_period,
   input its_pkg::its_cnt_t trans_period,
   input its_pkg::its_cnt_t boot_timer_count_field,
   input its_pkg::its_evt_t event_enable,
   input its_pkg::its_stat_t int_enable,
   input its_pkg::its_stat_t status_clear,
   output logic slave_clock_low_timeout_event,
   output logic master_clock_low_timeout_event,
   output logic master_arbitration_timeout_event,
   output logic master_byte_timeout_event,
   output logic slave_byte_timeout_event,
   output logic master_transaction_timeout_event,
   output logic slave_transaction_timeout_event,
   output logic boot_load_timeout_event,
   output logic slave_access_failed_status,
   output logic master_timeout_status,
   output logic master_arbitration_timeout_status,
   output logic boot_load_failed_status,
   output logic irq,
   output logic boot_done,
   output logic abort_no_stop,
   output logic release_lines,
   output logic engines_to_idle,
   output logic master_stop_abort,
   output logic master_abort,
   output logic slave_release,
   output logic bus_idle_assumed,
   output logic bus_busy
);
   import its_pkg::*;

   its_tmr_if tmr_if ();

   its_timer_bank u_bank (
      .core_clk (core_clk),
      .rst_n (rst_n),
      .t (tmr_if.tmr)
   );

   // ---- pin sampling and bus monitor
   logic scl_s1_q;
   logic scl_s2_q;
   logic scl_p_q;
   logic sda_s1_q;
   logic sda_s2_q;
   logic sda_p_q;
   logic busy_q;
   logic busy_d;
   logic [`ITS_IDLE_W-1:0] idle_cnt_q;
   logic [`ITS_IDLE_W-1:0] idle_cnt_d;
   logic idle_ok_q;
   logic idle_ok_d;
   logic byte_en_q;
   logic trn_en_q;
   logic start_det;
   logic stop_det;
   logic scl_fall;

   assign start_det = scl_s2_q && scl_p_q && sda_p_q && !sda_s2_q;
   assign stop_det = scl_s2_q && scl_p_q && !sda_p_q && sda_s2_q;
   assign scl_fall = scl_p_q && !scl_s2_q;

   always_comb
   begin
      busy_d = busy_q;
      if (start_det)
         busy_d = 1'b1;
      else if (stop_det || tmr_if.expire[`ITS_T_SCL])
         busy_d = 1'b0;
      idle_cnt_d = '0;
      idle_ok_d = 1'b0;
      // a master that vanished without a stop must not hang us
      if (master_waiting_idle && scl_s2_q && sda_s2_q)
      begin
         if (idle_cnt_q == `ITS_IDLE_W'(`ITS_IDLE_CYC - 1))
         begin
            idle_ok_d = 1'b1;
            busy_d = 1'b0;
         end
         else
            idle_cnt_d = `ITS_IDLE_W'(idle_cnt_q + 1'b1);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_p_q <= 1'b1;
         busy_q <= 1'b0;
         idle_cnt_q <= '0;
         idle_ok_q <= 1'b0;
         byte_en_q <= 1'b0;
         trn_en_q <= 1'b0;
      end
      else
      begin
         scl_s1_q <= scl_in;
         scl_s2_q <= scl_s1_q;
         scl_p_q <= scl_s2_q;
         sda_s1_q <= serial_data_line_in;
         sda_s2_q <= sda_s1_q;
         sda_p_q <= sda_s2_q;
         busy_q <= busy_d;
         idle_cnt_q <= idle_cnt_d;
         idle_ok_q <= idle_ok_d;
         byte_en_q <= byte_timeout_en;
         trn_en_q <= trans_timeout_en;
      end
   end

   // ---- timer control
   logic arb_run_q;
   logic arb_run_d;
   logic arb_exp_q;
   logic arb_exp_d;
   logic arb_fire;

   always_comb
   begin
      tmr_if.period[`ITS_T_SCL] = clock_low_period;
      tmr_if.period[`ITS_T_ARB] = arb_period;
      tmr_if.period[`ITS_T_BYTE] = byte_period;
      tmr_if.period[`ITS_T_TRN] = trans_period;
      tmr_if.period[`ITS_T_BOOT] = boot_timer_count_field;
      tmr_if.run = '0;
      tmr_if.restart = '0;
      tmr_if.run[`ITS_T_SCL] = clock_low_en && !scl_s2_q;
      tmr_if.restart[`ITS_T_SCL] = scl_s2_q;
      tmr_if.run[`ITS_T_ARB] = arb_run_q;
      tmr_if.run[`ITS_T_BYTE] = byte_en_q && (master_active || slave_active);
      tmr_if.restart[`ITS_T_BYTE] = byte_strobe;
      tmr_if.run[`ITS_T_TRN] = trn_en_q && busy_q;
      tmr_if.restart[`ITS_T_TRN] = start_det && !busy_q;
      tmr_if.run[`ITS_T_BOOT] = boot_active && !boot_end_normal;
   end

   // ---- arbitration timeout
   always_comb
   begin
      arb_run_d = arb_run_q;
      arb_exp_d = arb_exp_q;
      arb_fire = 1'b0;
      if (master_start_launch)
      begin
         arb_run_d = 1'b1;
         arb_exp_d = 1'b0;
      end
      if (arb_run_q && tmr_if.expire[`ITS_T_ARB])
         arb_exp_d = 1'b1;
      // a corrupted address leaves the timer running, but aborts the master once the timer has expired
      if (master_addr_done && !master_addr_collision)
      begin
         arb_run_d = 1'b0;
         arb_exp_d = 1'b0;
      end
      if (arb_exp_d && master_addr_collision)
         arb_fire = 1'b1;
      else if (arb_exp_d && master_waiting_idle && !master_addr_sending)
         arb_fire = 1'b1;
      else if (master_addr_collision)
         arb_run_d = arb_run_q;
      if (arb_fire || tmr_if.expire[`ITS_T_SCL])
      begin
         arb_run_d = 1'b0;
         arb_exp_d = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         arb_run_q <= 1'b0;
         arb_exp_q <= 1'b0;
      end
      else
      begin
         arb_run_q <= arb_run_d;
         arb_exp_q <= arb_exp_d;
      end
   end

   // ---- abort response sequencing
   its_resp_t rs_q;
   its_resp_t rs_d;
   logic trn_kind_q;
   logic trn_kind_d;
   logic boot_done_q;
   logic boot_done_d;
   logic ans_q;
   logic ans_d;
   logic rel_q;
   logic rel_d;
   logic idle_q;
   logic idle_d;
   logic mstop_q;
   logic mstop_d;
   logic mab_q;
   logic mab_d;
   logic srel_q;
   logic srel_d;
   its_evt_t hit;
   logic byte_x;
   logic trn_x;

   assign byte_x = tmr_if.expire[`ITS_T_BYTE];
   assign trn_x = tmr_if.expire[`ITS_T_TRN];

   always_comb
   begin
      rs_d = rs_q;
      trn_kind_d = trn_kind_q;
      boot_done_d = boot_done_q;
      hit = '0;
      ans_d = 1'b0;
      rel_d = 1'b0;
      idle_d = 1'b0;
      mstop_d = 1'b0;
      mab_d = 1'b0;
      srel_d = 1'b0;
      if (arb_fire)
      begin
         hit[`ITS_E_ARB] = 1'b1;
         mab_d = 1'b1;
      end
      // after a clean address phase a lost bus is fatal, no retry
      if (master_lost_bus && master_active && !arb_run_q)
         mab_d = 1'b1;
      unique case (rs_q)
         ITS_RS_IDLE:
         begin
            if (boot_active && tmr_if.expire[`ITS_T_BOOT])
            begin
               rs_d = ITS_RS_BOOT;
               boot_done_d = 1'b1;
            end
            else if ((byte_x || trn_x) && master_active)
            begin
               rs_d = ITS_RS_MASTER;
               trn_kind_d = trn_x;
            end
            else if ((byte_x || trn_x) && slave_active)
            begin
               rs_d = ITS_RS_SLAVE;
               trn_kind_d = trn_x;
            end
         end
         ITS_RS_MASTER:
         begin
            if (master_own_bit)
            begin
               mstop_d = 1'b1;
               hit[`ITS_E_MBYTE] = !trn_kind_q;
               hit[`ITS_E_MTRN] = trn_kind_q;
               rs_d = ITS_RS_IDLE;
            end
         end
         ITS_RS_SLAVE:
         begin
            if (scl_fall)
            begin
               srel_d = 1'b1;
               hit[`ITS_E_SBYTE] = !trn_kind_q;
               hit[`ITS_E_STRN] = trn_kind_q;
               rs_d = ITS_RS_IDLE;
            end
         end
         ITS_RS_BOOT:
         begin
            if (boot_byte_done)
            begin
               mstop_d = 1'b1;
               hit[`ITS_E_BOOT] = 1'b1;
               rs_d = ITS_RS_IDLE;
            end
         end
      endcase
      // a stuck clock leaves no way to send stop, so drop everything
      if (tmr_if.expire[`ITS_T_SCL])
      begin
         hit[`ITS_E_SCL_S] = slave_active;
         hit[`ITS_E_SCL_M] = master_active;
         ans_d = 1'b1;
         rel_d = 1'b1;
         idle_d = 1'b1;
         mstop_d = 1'b0;
         srel_d = 1'b0;
         rs_d = ITS_RS_IDLE;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rs_q <= ITS_RS_IDLE;
         trn_kind_q <= 1'b0;
         boot_done_q <= 1'b0;
         ans_q <= 1'b0;
         rel_q <= 1'b0;
         idle_q <= 1'b0;
         mstop_q <= 1'b0;
         mab_q <= 1'b0;
         srel_q <= 1'b0;
      end
      else
      begin
         rs_q <= rs_d;
         trn_kind_q <= trn_kind_d;
         boot_done_q <= boot_done_d;
         ans_q <= ans_d;
         rel_q <= rel_d;
         idle_q <= idle_d;
         mstop_q <= mstop_d;
         mab_q <= mab_d;
         srel_q <= srel_d;
      end
   end

   // ---- events, status and interrupt
   its_evt_t evt_q;
   its_evt_t evt_d;
   its_evt_t clr_evt;
   its_evt_t en_evt;
   its_stat_t stat_q;
   its_stat_t stat_d;
   logic irq_q;
   logic irq_d;

   always_comb
   begin
      clr_evt = '0;
      clr_evt[`ITS_E_SCL_S] = status_clear[`ITS_S_SAFAIL];
      clr_evt[`ITS_E_SBYTE] = status_clear[`ITS_S_SAFAIL];
      clr_evt[`ITS_E_STRN] = status_clear[`ITS_S_SAFAIL];
      clr_evt[`ITS_E_SCL_M] = status_clear[`ITS_S_MATMO];
      clr_evt[`ITS_E_MBYTE] = status_clear[`ITS_S_MATMO];
      clr_evt[`ITS_E_MTRN] = status_clear[`ITS_S_MATMO];
      clr_evt[`ITS_E_ARB] = status_clear[`ITS_S_MAATMO];
      clr_evt[`ITS_E_BOOT] = status_clear[`ITS_S_BLFAIL];
      // only enabled events are cleared; a new hit still wins
      evt_d = (evt_q & ~(clr_evt & event_enable)) | hit;
      en_evt = evt_d & event_enable;
      stat_d[`ITS_S_SAFAIL] = en_evt[`ITS_E_SCL_S] | en_evt[`ITS_E_SBYTE] | en_evt[`ITS_E_STRN];
      stat_d[`ITS_S_MATMO] = en_evt[`ITS_E_SCL_M] | en_evt[`ITS_E_MBYTE] | en_evt[`ITS_E_MTRN];
      stat_d[`ITS_S_MAATMO] = en_evt[`ITS_E_ARB];
      stat_d[`ITS_S_BLFAIL] = en_evt[`ITS_E_BOOT];
      irq_d = |(stat_d & int_enable);
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         evt_q <= '0;
         stat_q <= '0;
         irq_q <= 1'b0;
      end
      else
      begin
         evt_q <= evt_d;
         stat_q <= stat_d;
         irq_q <= irq_d;
      end
   end

   assign slave_clock_low_timeout_event = evt_q[`ITS_E_SCL_S];
   assign master_clock_low_timeout_event = evt_q[`ITS_E_SCL_M];
   assign master_arbitration_timeout_event = evt_q[`ITS_E_ARB];
   assign master_byte_timeout_event = evt_q[`ITS_E_MBYTE];
   assign slave_byte_timeout_event = evt_q[`ITS_E_SBYTE];
   assign master_transaction_timeout_event = evt_q[`ITS_E_MTRN];
   assign slave_transaction_timeout_event = evt_q[`ITS_E_STRN];
   assign boot_load_timeout_event = evt_q[`ITS_E_BOOT];
   assign slave_access_failed_status = stat_q[`ITS_S_SAFAIL];
   assign master_timeout_status = stat_q[`ITS_S_MATMO];
   assign master_arbitration_timeout_status = stat_q[`ITS_S_MAATMO];
   assign boot_load_failed_status = stat_q[`ITS_S_BLFAIL];
   assign irq = irq_q;
   assign boot_done = boot_done_q;
   assign abort_no_stop = ans_q;
   assign release_lines = rel_q;
   assign engines_to_idle = idle_q;
   assign master_stop_abort = mstop_q;
   assign master_abort = mab_q;
   assign slave_release = srel_q;
   assign bus_idle_assumed = idle_ok_q;
   assign bus_busy = busy_q;
endmodule

//--- dv/its_bus_model.sv
// far side of the bus: a clocking party or a device stuck holding the clock
`timescale 1ns/1ps
module its_bus_model (
   input wire logic run,
   input wire logic stuck_low,
   output logic scl,
   output logic sda
);
   logic lclk = 1'b1;
   logic dat = 1'b1;
   logic framed = 1'b0;
   initial
   begin
      // odd offset keeps the link clock out of phase with the core clock
      #37;
      forever
      begin
         #100;
         if (run && !framed)
         begin
            // start: data falls while the clock stands high
            dat = 1'b0;
            framed = 1'b1;
         end
         else if (run)
         begin
            lclk = ~lclk;
            if (lclk == 1'b0)
            begin
               dat = ~dat;
            end
         end
         else if (framed)
         begin
            // stop: data low under a low clock, clock up, then data up
            if (lclk && !dat)
            begin
               dat = 1'b1;
               framed = 1'b0;
            end
            else if (!lclk && !dat)
            begin
               lclk = 1'b1;
            end
            else
            begin
               lclk = 1'b0;
               dat = 1'b0;
            end
         end
      end
   end
   // lines are driven straight from lclk and dat, with no pull-ups; clock stands high between frames
   assign scl = stuck_low ? 1'b0 : lclk;
   assign sda = dat;
endmodule

//--- dv/its_checker.sv
// assertions on the timeout supervisor ports
`timescale 1ns/1ps
module its_checker (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic master_own_bit,
   input wire logic boot_byte_done,
   input wire logic byte_timeout_en,
   input its_pkg::its_evt_t event_enable,
   input its_pkg::its_stat_t int_enable,
   input wire logic slave_clock_low_timeout_event,
   input wire logic master_byte_timeout_event,
   input wire logic slave_byte_timeout_event,
   input wire logic slave_release,
   input wire logic master_arbitration_timeout_event,
   input wire logic boot_load_timeout_event,
   input wire logic slave_access_failed_status,
   input wire logic master_timeout_status,
   input wire logic master_arbitration_timeout_status,
   input wire logic boot_load_failed_status,
   input wire logic irq,
   input wire logic boot_done,
   input wire logic abort_no_stop,
   input wire logic release_lines,
   input wire logic engines_to_idle,
   input wire logic master_stop_abort,
   input wire logic master_abort,
   input wire logic bus_idle_assumed,
   input wire logic bus_busy
);
   import its_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_abort_trio;
      abort_no_stop && release_lines && engines_to_idle;
   endsequence
   a_scl_low_abort: assert property ($rose(slave_clock_low_timeout_event) |-> s_abort_trio)
      else $error("clock-low event without abort");
   a_abort_no_stop: assert property (abort_no_stop |-> release_lines && engines_to_idle && !master_stop_abort)
      else $error("clock-low abort incomplete");
   a_low_was_low: assert property (abort_no_stop |-> $past(scl_in, 3) == 1'b0)
      else $error("clock-low abort while clock high");
   a_byte_stop: assert property ($rose(master_byte_timeout_event) |-> master_stop_abort)
      else $error("byte event without stop");
   a_slave_byte_release: assert property ($rose(slave_byte_timeout_event) |-> slave_release)
      else $error("slave byte event without release");
   a_byte_enabled: assert property ($rose(master_byte_timeout_event) |-> $past(byte_timeout_en, 2))
      else $error("byte event while disabled");
   a_stop_after_bit: assert property (master_stop_abort |-> $past(master_own_bit) || $past(master_own_bit, 2)
      || $past(boot_byte_done) || $past(boot_byte_done, 2))
      else $error("stop without owned bit");
   a_arb_status: assert property ($rose(master_arbitration_timeout_event) && event_enable[2]
      |-> master_arbitration_timeout_status && master_abort)
      else $error("arbitration event without abort");
   a_boot_done_first: assert property (boot_load_timeout_event |-> boot_done)
      else $error("boot event without boot done");
   a_irq_gate: assert property (irq == |({boot_load_failed_status, master_arbitration_timeout_status,
      master_timeout_status, slave_access_failed_status} & $past(int_enable)))
      else $error("interrupt gating wrong");
   a_idle_single: assert property (bus_idle_assumed |-> !bus_busy ##1 !bus_idle_assumed)
      else $error("idle pulse wrong");
endmodule

bind its_timeout_supervisor its_checker its_checker_inst (.*);

//--- dv/its_timeout_supervisor_tb.sv
// self-checking bench for the timeout supervisor
`timescale 1ns/1ps
`include "its_defs.svh"
module its_timeout_supervisor_tb;
   import its_pkg::*;
   logic core_clk, rst_n, scl_in, serial_data_line_in, master_active, slave_active, master_start_launch;
   logic master_addr_sending, master_addr_done, master_addr_collision, master_waiting_idle, master_lost_bus;
   logic master_own_bit, byte_strobe, boot_active, boot_end_normal, boot_byte_done, clock_low_en;
   logic byte_timeout_en, trans_timeout_en, run, stuck, clr_c;
   its_cnt_t clock_low_period, arb_period, byte_period, trans_period, boot_timer_count_field;
   its_evt_t event_enable, exp_ev;
   its_stat_t int_enable, status_clear;
   logic slave_clock_low_timeout_event, master_clock_low_timeout_event, master_arbitration_timeout_event;
   logic master_byte_timeout_event, slave_byte_timeout_event, master_transaction_timeout_event;
   logic slave_transaction_timeout_event, boot_load_timeout_event, slave_access_failed_status;
   logic master_timeout_status, master_arbitration_timeout_status, boot_load_failed_status, irq, boot_done;
   logic abort_no_stop, release_lines, engines_to_idle, master_stop_abort, master_abort, slave_release;
   logic bus_idle_assumed, bus_busy;
   logic [7:0] caught;
   int err_total, n_tests, seed;
   wire its_evt_t evs = {boot_load_timeout_event, slave_transaction_timeout_event,
      master_transaction_timeout_event, slave_byte_timeout_event, master_byte_timeout_event,
      master_arbitration_timeout_event, master_clock_low_timeout_event, slave_clock_low_timeout_event};
   wire its_stat_t stat = {boot_load_failed_status, master_arbitration_timeout_status, master_timeout_status,
      slave_access_failed_status};
   wire [7:0] pul = {boot_done, bus_idle_assumed, slave_release, master_abort, master_stop_abort,
      engines_to_idle, release_lines, abort_no_stop};

   its_timeout_supervisor its_timeout_supervisor_inst (.*);
   its_bus_model its_bus_model_inst (.run(run), .stuck_low(stuck), .scl(scl_in), .sda(serial_data_line_in));

   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // one-cycle pulses are caught here so no edge race can hide them
   always @(posedge core_clk) caught <= clr_c ? 8'h00 : (caught | pul);

   function automatic its_stat_t exp_stat(input its_evt_t e);
      its_evt_t m;
      m = e & event_enable;
      exp_stat = {m[7], m[2], m[1] | m[3] | m[5], m[0] | m[4] | m[6]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("mismatches=%0d compares=%0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic clr;
      @(posedge core_clk);
      clr_c <= 1'b1;
      @(posedge core_clk);
      clr_c <= 1'b0;
   endtask
   task automatic wait_hit(input int k, input int lim, input bit on_evt);
      int i;
      for (i = 0; i < lim; i++)
      begin
         @(posedge core_clk);
         #1;
         if ((on_evt ? evs[k] : caught[k]) === 1'b1)
         begin
            break;
         end
      end
      if (i == lim)
      begin
         err_total++;
         test_done;
      end
      tick(1);
   endtask
   task automatic chk_all;
      #1;
      chk(evs, exp_ev);
      chk(stat, exp_stat(exp_ev));
      chk(irq, |(exp_stat(exp_ev) & int_enable));
   endtask
   task automatic clear_stat(input its_stat_t b, input its_evt_t gone);
      @(posedge core_clk);
      status_clear <= b;
      @(posedge core_clk);
      status_clear <= '0;
      exp_ev = exp_ev & ~gone;
      tick(3);
      chk_all;
   endtask

   initial
   begin
      seed = 63;
      err_total = 0;
      n_tests = 0;
      rst_n = 1'b0;
      {master_active, slave_active, master_start_launch, master_addr_sending, master_addr_done} = '0;
      {master_addr_collision, master_waiting_idle, master_lost_bus, master_own_bit, byte_strobe} = '0;
      {boot_active, boot_end_normal, boot_byte_done, clock_low_en, byte_timeout_en, trans_timeout_en} = '0;
      {run, stuck, clr_c, status_clear, exp_ev} = '0;
      {arb_period, byte_period, trans_period, boot_timer_count_field} = '0;
      clock_low_period = 24'h00_000a;
      event_enable = 8'hff;
      int_enable = 4'h1 | 4'($random(seed));
      tick(10);
      rst_n <= 1'b1;
      tick(3);
      clr;
      chk_all;
      chk(boot_done, 1'b0);
      // a clock that keeps toggling must never trip the clock-low timer
      {master_active, slave_active, clock_low_en, run} <= 4'b1111;
      tick(200);
      chk_all;
      stuck <= 1'b1;
      wait_hit(`ITS_E_SCL_S, 100, 1'b1);
      exp_ev[`ITS_E_SCL_S] = 1'b1;
      exp_ev[`ITS_E_SCL_M] = 1'b1;
      chk_all;
      chk(caught[2:0], 3'h7);
      chk(caught[3], 1'b0);
      {stuck, master_active, slave_active, run} <= 4'b0000;
      clr;
      clear_stat(4'h3, 8'h7b);
      // byte timer stays quiet until software enables it
      master_active <= 1'b1;
      byte_period <= 24'h00_0008 + 24'($random(seed) & 7);
      tick(100);
      chk_all;
      byte_timeout_en <= 1'b1;
      tick(40 + ($random(seed) & 15));
      chk_all;
      master_own_bit <= 1'b1;
      @(posedge core_clk);
      master_own_bit <= 1'b0;
      wait_hit(`ITS_E_MBYTE, 10, 1'b1);
      exp_ev[`ITS_E_MBYTE] = 1'b1;
      chk_all;
      chk(caught[3], 1'b1);
      {master_active, byte_timeout_en} <= 2'b00;
      clr;
      clear_stat(4'h2, 8'h2a);
      master_waiting_idle <= 1'b1;
      wait_hit(6, 2200, 1'b0);
      chk(bus_busy, 1'b0);
      // clean address phase stops the arbitration timer
      master_waiting_idle <= 1'b0;
      arb_period <= 24'h00_0014;
      master_start_launch <= 1'b1;
      @(posedge core_clk);
      {master_start_launch, master_addr_done} <= 2'b01;
      @(posedge core_clk);
      {master_addr_done, master_waiting_idle, master_active} <= 3'b011;
      tick(60);
      chk_all;
      clr;
      master_lost_bus <= 1'b1;
      @(posedge core_clk);
      master_lost_bus <= 1'b0;
      tick(3);
      chk(caught[4], 1'b1);
      master_active <= 1'b0;
      clr;
      arb_period <= 24'h00_000c + 24'($random(seed) & 15);
      master_start_launch <= 1'b1;
      @(posedge core_clk);
      master_start_launch <= 1'b0;
      wait_hit(`ITS_E_ARB, 60, 1'b1);
      exp_ev[`ITS_E_ARB] = 1'b1;
      chk_all;
      chk(caught[4], 1'b1);
      master_waiting_idle <= 1'b0;
      clear_stat(4'h4, 8'h04);
      // expiry mid address holds off, a collision then aborts at once
      {master_addr_sending, master_start_launch} <= 2'b11;
      @(posedge core_clk);
      master_start_launch <= 1'b0;
      tick(60);
      chk_all;
      master_addr_collision <= 1'b1;
      @(posedge core_clk);
      {master_addr_collision, master_addr_sending} <= 2'b00;
      wait_hit(`ITS_E_ARB, 5, 1'b1);
      exp_ev[`ITS_E_ARB] = 1'b1;
      chk_all;
      // zero boot count keeps the boot timer silent
      boot_active <= 1'b1;
      tick(100);
      chk(boot_done, 1'b0);
      boot_active <= 1'b0;
      @(posedge core_clk);
      boot_timer_count_field <= 24'h00_000c;
      @(posedge core_clk);
      boot_active <= 1'b1;
      clr;
      wait_hit(7, 40, 1'b0);
      chk_all;
      boot_byte_done <= 1'b1;
      @(posedge core_clk);
      boot_byte_done <= 1'b0;
      wait_hit(`ITS_E_BOOT, 10, 1'b1);
      exp_ev[`ITS_E_BOOT] = 1'b1;
      chk_all;
      chk(caught[3], 1'b1);
      // slave byte then transaction expiry, both let go at the next clock fall
      {boot_active, slave_active, byte_timeout_en} <= 3'b011;
      byte_period <= 24'h00_0006;
      tick(20);
      run <= 1'b1;
      wait_hit(`ITS_E_SBYTE, 40, 1'b1);
      exp_ev[`ITS_E_SBYTE] = 1'b1;
      chk_all;
      chk(caught[5], 1'b1);
      {byte_timeout_en, trans_timeout_en} <= 2'b01;
      trans_period <= 24'h00_0010;
      wait_hit(`ITS_E_STRN, 60, 1'b1);
      exp_ev[`ITS_E_STRN] = 1'b1;
      chk_all;
      chk(bus_busy, 1'b1);
      run <= 1'b0;
      tick(20);
      chk(bus_busy, 1'b0);
      test_done;
   end
endmodule
